// ===== src/ivc_defs.svh
`ifndef IVC_DEFS_SVH
`define IVC_DEFS_SVH
`define NUM_VEC 32
`define VEC_W 5
`define PRIO_W 3
`define ADDR_W 16
`define DEPTH_W 4
`define MAX_DEPTH 4'h8
`define NUM_DMA_CH 16
`define AXI_AW 12
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REG_ENABLE 12'h000
`define REG_PEND_SET 12'h004
`define REG_PEND_CLR 12'h008
`define REG_STATUS 12'h00C
`define REG_PRIO 12'h010
`define REG_PRIO_END 12'h020
`define REG_SRC 12'h020
`define REG_SRC_END 12'h028
`define REG_VADDR 12'h080
`define REG_VADDR_END 12'h100
`define PRIO_FLD 4
`define PRIO_PER_WORD 8
`define SRC_FLD 2
`define SRC_PER_WORD 16
`define STAT_DEPTH_LSB 0
`define STAT_LEVEL_LSB 4
`define STAT_VEC_LSB 8
`define STAT_REQ_BIT 16
`define PRIO_RST 3'h7
`define VADDR_RST 16'h0000
`endif

// ===== src/ivc_pkg.sv
package ivc_pkg;
   typedef enum logic [1:0] {
      SRC_FIXED = 2'h0,
      SRC_DMA = 2'h1,
      SRC_FABRIC = 2'h2,
      SRC_OFF = 2'h3
   } src_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_REQ = 2'h1,
      ST_VECT = 2'h3
   } state_t;
endpackage : ivc_pkg

// ===== src/isr_addr_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "ivc_defs.svh"
module isr_addr_mem (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [`VEC_W-1:0] waddr,
   input wire logic [`ADDR_W-1:0] wdata,
   input wire logic [1:0] wbe,
   input wire logic [`VEC_W-1:0] raddr_a,
   output logic [`ADDR_W-1:0] rdata_a,
   input wire logic [`VEC_W-1:0] raddr_b,
   output logic [`ADDR_W-1:0] rdata_b
);
   logic [`ADDR_W-1:0] mem [`NUM_VEC];

   // Handler addresses, byte-lane writable
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < `NUM_VEC; i++) mem[i] <= `VADDR_RST;
      end else if (we) begin
         if (wbe[0]) mem[waddr][7:0] <= wdata[7:0];
         if (wbe[1]) mem[waddr][15:8] <= wdata[15:8];
      end
   end

   // Registered read ports: core lookup and bus
   always_ff @(posedge clock) begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule : isr_addr_mem
`default_nettype wire

// ===== src/priority_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "ivc_defs.svh"
module priority_select (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`NUM_VEC-1:0] eligible,
   input wire logic [`NUM_VEC*`PRIO_W-1:0] prio_flat,
   output logic found,
   output logic [`VEC_W-1:0] index,
   output logic [`PRIO_W-1:0] level
);
   logic bad;

   // Downward scan, so an equal level at a lower index takes over
   always_comb begin
      found = 1'b0;
      index = '0;
      level = '0;
      for (int i = `NUM_VEC - 1; i >= 0; i--) begin
         if (eligible[i] && (!found || prio_flat[i*`PRIO_W +: `PRIO_W] <= level)) begin
            found = 1'b1;
            index = `VEC_W'(i);
            level = prio_flat[i*`PRIO_W +: `PRIO_W];
         end
      end
   end

   // Checker helper: any better candidate than the winner
   always_comb begin
      bad = 1'b0;
      for (int i = 0; i < `NUM_VEC; i++) begin
         if (eligible[i] && (prio_flat[i*`PRIO_W +: `PRIO_W] < level
             || (prio_flat[i*`PRIO_W +: `PRIO_W] == level && `VEC_W'(i) < index)))
            bad = 1'b1;
      end
   end

   chk_winner_lowest_index: assert property (
      @(posedge clock) disable iff (!rst_n) found |-> !bad && eligible[index])
      else $error("winner is not the most urgent lowest index");
endmodule : priority_select
`default_nettype wire

// ===== src/vectored_priority_interrupt_ctrl.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ivc_defs.svh"
module vectored_priority_interrupt_ctrl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [`NUM_VEC-1:0] fixed_irq,
   input wire logic [`NUM_DMA_CH-1:0] dma_term_first,
   input wire logic [`NUM_DMA_CH-1:0] dma_terminal_out,
   input wire logic [`NUM_VEC-1:0] fabric_irq,
   input wire logic core_ack,
   input wire logic core_reti,
   output logic irq_req,
   output logic [`VEC_W-1:0] irq_vector,
   output logic isr_valid,
   output logic [`ADDR_W-1:0] isr_addr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ivc_pkg::state_t state;
   ivc_pkg::src_t src [`NUM_VEC];
   logic [`NUM_VEC-1:0] enable, pending, fab_meta, fab_sync, req_prev, req_sel;
   logic [`NUM_VEC-1:0] hw_set, sw_set, sw_clr, take_mask, dma_lines;
   logic [`NUM_VEC*`PRIO_W-1:0] prio_flat;
   logic [`PRIO_W-1:0] prio [`NUM_VEC];
   logic [`PRIO_W-1:0] lvl_stack [`MAX_DEPTH];
   logic [`DEPTH_W-1:0] depth;
   logic [`PRIO_W-1:0] cur_level, win_level;
   logic [`VEC_W-1:0] win_index;
   logic win_found, preempt, take;
   logic aw_full, w_full, wr_fire, wr_ok, ar_pend, rd_ok;
   logic [`AXI_AW-1:0] aw_addr, ar_addr;
   logic [31:0] w_data, wmask, rd_word;
   logic [3:0] w_strb;
   logic wr_enable, wr_set, wr_clr, wr_prio, wr_src, wr_vaddr;
   logic [`ADDR_W-1:0] bus_vaddr;
   logic [`DEPTH_W-1:0] past_depth;

   // Fabric lines may come from pins, so two flops before use
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fab_meta <= '0;
         fab_sync <= '0;
      end else begin
         fab_meta <= fabric_irq;
         fab_sync <= fab_meta;
      end
   end

   // Channel n first line feeds vector n, its second line vector 16+n
   assign dma_lines = {dma_terminal_out, dma_term_first};

   // Per-vector source choice; fabric also carries port and rerouted lines
   for (genvar g = 0; g < `NUM_VEC; g++) begin : g_src
      always_comb begin
         case (src[g])
            ivc_pkg::SRC_FIXED: req_sel[g] = fixed_irq[g];
            ivc_pkg::SRC_DMA: req_sel[g] = dma_lines[g];
            ivc_pkg::SRC_FABRIC: req_sel[g] = fab_sync[g];
            default: req_sel[g] = 1'b0;
         endcase
      end
      assign prio_flat[g*`PRIO_W +: `PRIO_W] = prio[g];
   end

   // Edge detect, so a held level request is not retaken after service
   always_ff @(posedge clock) begin
      if (!rst_n) req_prev <= '0;
      else req_prev <= req_sel;
   end
   assign hw_set = req_sel & ~req_prev;

   // Pending latch: any set beats any clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) pending <= '0;
      else pending <= (pending & ~sw_clr & ~take_mask) | sw_set | hw_set;
   end

   priority_select u_select (
      .clock(clock),
      .rst_n(rst_n),
      .eligible(pending & enable),
      .prio_flat(prio_flat),
      .found(win_found),
      .index(win_index),
      .level(win_level)
   );

   // Preemption needs strictly more urgent level and a free nesting slot
   assign cur_level = lvl_stack[3'(depth - 4'h1)];
   assign preempt = win_found && (depth == '0
      || (depth != `MAX_DEPTH && win_level < cur_level));
   assign irq_req = state == ivc_pkg::ST_REQ && preempt && win_index == irq_vector;
   assign take = irq_req && core_ack;
   assign take_mask = take ? (32'h1 << irq_vector) : '0;
   assign isr_valid = state == ivc_pkg::ST_VECT;

   // Request sequencing toward the core
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= ivc_pkg::ST_IDLE;
         irq_vector <= '0;
      end else begin
         case (state)
            ivc_pkg::ST_IDLE: begin
               if (preempt) begin
                  state <= ivc_pkg::ST_REQ;
                  irq_vector <= win_index;
               end
            end
            ivc_pkg::ST_REQ: begin
               if (take) state <= ivc_pkg::ST_VECT;
               else if (!preempt) state <= ivc_pkg::ST_IDLE;
               else irq_vector <= win_index;
            end
            default: state <= ivc_pkg::ST_IDLE;
         endcase
      end
   end

   // Nesting stack of active levels; push on take, pop on return
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         depth <= '0;
         for (int i = 0; i < `MAX_DEPTH; i++) lvl_stack[i] <= '0;
      end else if (take && core_reti && depth != '0) begin
         lvl_stack[3'(depth - 4'h1)] <= win_level;
      end else if (take) begin
         lvl_stack[depth[2:0]] <= win_level;
         depth <= depth + 4'h1;
      end else if (core_reti && depth != '0) begin
         depth <= depth - 4'h1;
      end
   end

   // Handler address table; core port is read by the vector held at take
   isr_addr_mem u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .we(wr_vaddr),
      .waddr(aw_addr[6:2]),
      .wdata(w_data[`ADDR_W-1:0]),
      .wbe(w_strb[1:0]),
      .raddr_a(irq_vector),
      .rdata_a(isr_addr),
      .raddr_b(araddr[6:2]),
      .rdata_b(bus_vaddr)
   );

   // Write channel capture; address and data may come in either order
   assign awready = !aw_full;
   assign wready = !w_full;
   assign wr_fire = aw_full && w_full && !bvalid;
   assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wr_fire) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
      end else begin
         if (awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
      end
   end

   // Write decode
   always_comb begin
      wr_enable = 1'b0;
      wr_set = 1'b0;
      wr_clr = 1'b0;
      wr_prio = 1'b0;
      wr_src = 1'b0;
      wr_vaddr = 1'b0;
      wr_ok = 1'b1;
      if (aw_addr[11:2] == `REG_ENABLE >> 2) wr_enable = wr_fire;
      else if (aw_addr[11:2] == `REG_PEND_SET >> 2) wr_set = wr_fire;
      else if (aw_addr[11:2] == `REG_PEND_CLR >> 2) wr_clr = wr_fire;
      else if (aw_addr[11:2] == `REG_STATUS >> 2) wr_ok = 1'b1;
      else if (aw_addr >= `REG_PRIO && aw_addr < `REG_PRIO_END) wr_prio = wr_fire;
      else if (aw_addr >= `REG_SRC && aw_addr < `REG_SRC_END) wr_src = wr_fire;
      else if (aw_addr >= `REG_VADDR && aw_addr < `REG_VADDR_END) wr_vaddr = wr_fire;
      else wr_ok = 1'b0;
   end
   assign sw_set = wr_set ? (w_data & wmask) : '0;
   assign sw_clr = wr_clr ? (w_data & wmask) : '0;

   // Write response, one write at a time
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Enable register
   always_ff @(posedge clock) begin
      if (!rst_n) enable <= '0;
      else if (wr_enable) enable <= (enable & ~wmask) | (w_data & wmask);
   end

   // Priority and source fields; new values apply to the next arbitration
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < `NUM_VEC; i++) begin
            prio[i] <= `PRIO_RST;
            src[i] <= ivc_pkg::SRC_FIXED;
         end
      end else begin
         for (int i = 0; i < `NUM_VEC; i++) begin
            if (wr_prio && aw_addr[3:2] == 2'(i / `PRIO_PER_WORD)
                && w_strb[(i % `PRIO_PER_WORD) / 2])
               prio[i] <= w_data[(i % `PRIO_PER_WORD) * `PRIO_FLD +: `PRIO_W];
            if (wr_src && aw_addr[2] == 1'(i / `SRC_PER_WORD)
                && w_strb[(i % `SRC_PER_WORD) / 4])
               src[i] <= ivc_pkg::src_t'(w_data[(i % `SRC_PER_WORD) * `SRC_FLD +: `SRC_FLD]);
         end
      end
   end

   // Read data mux for the address taken one cycle earlier
   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      if (ar_addr[11:2] == `REG_ENABLE >> 2) rd_word = enable;
      else if (ar_addr[11:2] == `REG_PEND_SET >> 2) rd_word = pending;
      else if (ar_addr[11:2] == `REG_PEND_CLR >> 2) rd_word = pending;
      else if (ar_addr[11:2] == `REG_STATUS >> 2) begin
         rd_word[`STAT_DEPTH_LSB +: `DEPTH_W] = depth;
         rd_word[`STAT_LEVEL_LSB +: `PRIO_W] = depth == '0 ? '0 : cur_level;
         rd_word[`STAT_VEC_LSB +: `VEC_W] = irq_vector;
         rd_word[`STAT_REQ_BIT] = irq_req;
      end else if (ar_addr >= `REG_PRIO && ar_addr < `REG_PRIO_END) begin
         for (int j = 0; j < `PRIO_PER_WORD; j++)
            rd_word[j * `PRIO_FLD +: `PRIO_W] = prio[{ar_addr[3:2], 3'(j)}];
      end else if (ar_addr >= `REG_SRC && ar_addr < `REG_SRC_END) begin
         for (int j = 0; j < `SRC_PER_WORD; j++)
            rd_word[j * `SRC_FLD +: `SRC_FLD] = src[{ar_addr[2], 4'(j)}];
      end else if (ar_addr >= `REG_VADDR && ar_addr < `REG_VADDR_END)
         rd_word[`ADDR_W-1:0] = bus_vaddr;
      else rd_ok = 1'b0;
   end

   // Read channel: address, one cycle for table lookup, then data
   assign arready = !ar_pend && !rvalid;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ar_pend <= 1'b0;
         ar_addr <= '0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `RESP_OKAY;
      end else if (ar_pend) begin
         ar_pend <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid) begin
         if (rready) rvalid <= 1'b0;
      end else if (arvalid) begin
         ar_pend <= 1'b1;
         ar_addr <= araddr;
      end
   end

   // Helper for the nesting checks
   always_ff @(posedge clock) begin
      if (!rst_n) past_depth <= '0;
      else past_depth <= depth;
   end

   chk_req_enabled: assert property (irq_req |-> enable[irq_vector] && pending[irq_vector])
      else $error("request shown for a disabled or idle vector");
   chk_take_clears: assert property (take && !hw_set[irq_vector] && !sw_set[irq_vector]
      |=> !pending[$past(irq_vector)])
      else $error("taken vector still pending");
   chk_addr_after_take: assert property (take |=> isr_valid ##1 !isr_valid)
      else $error("handler address not presented once after take");
   chk_nest_push: assert property (take && !core_reti |=> depth == past_depth + 4'h1)
      else $error("nesting depth did not grow on take");
   chk_nest_limit: assert property (depth == `MAX_DEPTH |-> !irq_req && depth <= `MAX_DEPTH)
      else $error("request beyond nesting limit");
   chk_preempt_level: assert property (irq_req && depth != '0 |-> win_level < cur_level)
      else $error("request does not outrank running level");
   chk_sw_set: assert property (wr_set && sw_set != '0
      |=> (pending & $past(sw_set)) == $past(sw_set))
      else $error("software set did not mark pending");
   chk_sw_clear: assert property (wr_clr && hw_set == '0
      |=> (pending & $past(sw_clr)) == '0)
      else $error("software clear did not remove pending");
   chk_reti_pop: assert property (core_reti && !take && depth != '0
      |=> depth == past_depth - 4'h1)
      else $error("return did not release a level");
endmodule : vectored_priority_interrupt_ctrl
`default_nettype wire

// ===== verification/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ack_en,
   input wire logic reti_go,
   input wire logic irq_req,
   input wire logic isr_valid,
   output logic core_ack,
   output logic core_reti
);
   // Ack one cycle after a seen request; stay quiet while a vector lands
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         core_ack <= 1'b0;
      end else begin
         core_ack <= ack_en && irq_req && !core_ack && !isr_valid;
      end
   end

   // Return from handler on command of the bench
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         core_reti <= 1'b0;
      end else begin
         core_reti <= reti_go;
      end
   end
endmodule : core_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ivc_defs.svh"
module testbench;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [`AXI_AW-1:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq_req, isr_valid, core_ack, core_reti;
   logic [1:0] bresp, rresp;
   logic [`NUM_VEC-1:0] fixed_irq = 32'h0, fabric_irq = 32'h0;
   logic [`NUM_DMA_CH-1:0] dma_first = 16'h0, dma_second = 16'h0;
   logic ack_en = 1'b0, reti_go = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic [`VEC_W-1:0] irq_vector, last_vec = 5'h00;
   logic [`ADDR_W-1:0] isr_addr, last_addr = 16'h0000, vtab [32];
   int errors = 0, tests_run = 0, takes = 0;

   always #5 clock = ~clock;

   vectored_priority_interrupt_ctrl dut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .fixed_irq(fixed_irq), .dma_term_first(dma_first),
      .dma_terminal_out(dma_second), .fabric_irq(fabric_irq), .core_ack(core_ack),
      .core_reti(core_reti), .irq_req(irq_req), .irq_vector(irq_vector),
      .isr_valid(isr_valid), .isr_addr(isr_addr));

   core_model core (.clock(clock), .rst_n(rst_n), .ack_en(ack_en), .reti_go(reti_go),
      .irq_req(irq_req), .isr_valid(isr_valid), .core_ack(core_ack), .core_reti(core_reti));

   // Record every vector the core enters
   always @(posedge clock) begin
      if (isr_valid === 1'b1) begin
         takes <= takes + 1;
         last_vec <= irq_vector;
         last_addr <= isr_addr;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 100);
      r = bresp;
      bready <= 1'b0;
      if (n >= 100) errors++;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 100) errors++;
   endtask : rd

   task automatic wrc(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      check("bresp", {30'h0, r}, {30'h0, `RESP_OKAY});
   endtask : wrc

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check($sformatf("reg %h", a), d, exp);
      check("rresp", {30'h0, r}, {30'h0, `RESP_OKAY});
   endtask : rdc

   // Bounded wait for the next entry, then compare vector and handler
   task automatic wait_take(input int t0, input int v);
      int n;
      n = 0;
      while (takes == t0 && n < 300) begin
         @(posedge clock);
         n++;
      end
      check("taken", {31'h0, takes != t0}, 32'h1);
      check("vector", {27'h0, last_vec}, v);
      check("isr addr", {16'h0, last_addr}, {16'h0, vtab[v]});
   endtask : wait_take

   task automatic reti_n(input int k);
      repeat (k) begin
         @(posedge clock);
         reti_go <= 1'b1;
         @(posedge clock);
         reti_go <= 1'b0;
      end
   endtask : reti_n

   // Hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #300000;
      errors++;
      complete_run();
   end

   initial begin
      int t0, a, b;
      logic [31:0] d;
      logic [1:0] r;
      void'($urandom(26314));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rdc(`REG_ENABLE, 32'h0);
      rdc(`REG_PEND_SET, 32'h0);
      for (int i = 0; i < 4; i++) rdc(`REG_PRIO + 4 * i, 32'h77777777);
      rdc(`REG_SRC, 32'h0);
      rd(12'h040, d, r);
      check("unmapped rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
      check("unmapped rdata", d, 32'h0);
      wr(12'h044, 32'hFFFFFFFF, r);
      check("unmapped bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
      $display("reset values done");
      // Random handler table, upper lanes ignored
      for (int v = 0; v < 32; v++) begin
         d = $urandom;
         vtab[v] = d[15:0];
         wrc(`REG_VADDR + 4 * v, d);
         rdc(`REG_VADDR + 4 * v, {16'h0, vtab[v]});
      end
      // Low lane only: upper byte of the entry must keep its old value
      wstrb <= 4'h1;
      wrc(`REG_VADDR + 4 * 5, 32'h0000A5A5);
      wstrb <= 4'hF;
      vtab[5][7:0] = 8'hA5;
      rdc(`REG_VADDR + 4 * 5, {16'h0, vtab[5]});
      $display("handler table done");
      a = $urandom_range(31, 0);
      wrc(`REG_PEND_SET, 32'h1 << a);
      rdc(`REG_PEND_SET, 32'h1 << a);
      repeat (10) @(posedge clock);
      check("disabled req", {31'h0, irq_req}, 32'h0);
      wrc(`REG_PEND_CLR, 32'h1 << a);
      rdc(`REG_PEND_CLR, 32'h0);
      $display("software pending done");
      // Equal levels: lower index first, the other waits for the return
      a = $urandom_range(15, 0);
      b = $urandom_range(31, 16);
      wrc(`REG_ENABLE, 32'hFFFFFFFF);
      wrc(`REG_PEND_SET, (32'h1 << a) | (32'h1 << b));
      repeat (5) @(posedge clock);
      check("tie vector", {26'h0, irq_req, irq_vector}, 32'h20 | a);
      t0 = takes;
      ack_en <= 1'b1;
      wait_take(t0, a);
      repeat (8) @(posedge clock);
      check("equal no preempt", takes, t0 + 1);
      t0 = takes;
      reti_n(1);
      wait_take(t0, b);
      reti_n(1);
      $display("tie break done");
      // Vector k at level 7-k: each one preempts, eight deep
      wrc(`REG_PRIO, 32'h01234567);
      for (int k = 0; k < 8; k++) begin
         t0 = takes;
         wrc(`REG_PEND_SET, 32'h1 << k);
         wait_take(t0, k);
      end
      rd(`REG_STATUS, d, r);
      check("depth 8", {25'h0, d[6:0]}, 32'h08);
      reti_n(8);
      rd(`REG_STATUS, d, r);
      check("depth 0", {28'h0, d[3:0]}, 32'h0);
      $display("nesting done");
      ack_en <= 1'b0;
      wrc(`REG_PRIO + 8, 32'h77727777);
      wrc(`REG_PEND_SET, 32'h00100200);
      repeat (4) @(posedge clock);
      check("prio winner", {27'h0, irq_vector}, 32'h14);
      wrc(`REG_PRIO + 4, 32'h77777707);
      repeat (4) @(posedge clock);
      check("prio change", {27'h0, irq_vector}, 32'h09);
      wrc(`REG_PEND_CLR, 32'hFFFFFFFF);
      repeat (3) @(posedge clock);
      check("cleared req", {31'h0, irq_req}, 32'h0);
      $display("priority done");
      // Vec 2 and 18 on DMA, 30 on fabric, 13 off; 12 stays on its fixed line
      wrc(`REG_ENABLE, 32'h0);
      wrc(`REG_SRC, 32'h0C000010);
      rdc(`REG_SRC, 32'h0C000010);
      wrc(`REG_SRC + 4, 32'h20000010);
      rdc(`REG_SRC + 4, 32'h20000010);
      fixed_irq <= 32'h00003004;
      dma_first <= 16'h0004;
      dma_second <= 16'h0004;
      fabric_irq <= 32'h40001000;
      repeat (2) @(posedge clock);
      fixed_irq <= 32'h0;
      dma_first <= 16'h0;
      dma_second <= 16'h0;
      fabric_irq <= 32'h0;
      repeat (6) @(posedge clock);
      rdc(`REG_PEND_SET, 32'h40041004);
      $display("sources done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
